/* File: rtl/lcdm_pkg.sv */
// How it works
// - the common lines are driven one at a time (one per half on a dual screen) in scan order while the active row's segments show their bits.
// - every segment and common crossing is one pixel with its own bit.
// - row data enters four bits at a time, one nibble per shift clock.
// - each line latch copies the shifted row onto the segments for the current common line.
// - the display shows while the display-on input is high and is blank while it is low.
// - a single screen uses one nibble group, a dual screen two groups clocked together.
package lcdm_pkg;

   // nibble width of each data group
   localparam int NIB_W = 4;

   // default panel geometry
   localparam int SEG_COUNT_DEF = 64;
   localparam int ROW_COUNT_DEF = 64;

   // system clock rate
   localparam int CLK_MHZ = 125;

   // link timing in ns
   localparam int SHIFT_TO_LATCH_NS = 125;
   localparam int LATCH_HIGH_NS = 125;
   localparam int LATCH_TO_SHIFT_NS = 80;
   localparam int FRAME_SETUP_NS = 100;

   // longest time, rounded down, at least one cycle
   localparam int LATCH_TO_SHIFT_CYC_RAW = (LATCH_TO_SHIFT_NS * CLK_MHZ) / 1000;
   localparam int LATCH_TO_SHIFT_CYC =
      (LATCH_TO_SHIFT_CYC_RAW < 1) ? 1 : LATCH_TO_SHIFT_CYC_RAW;

   // least time, rounded up
   localparam int LATCH_HIGH_CYC = (LATCH_HIGH_NS * CLK_MHZ + 999) / 1000;

   // synchroniser depth
   localparam int SYNC_STAGES = 2;

   // control pins after the crossing
   typedef struct packed {
      logic line_latch;
      logic frame_start;
      logic ac_polarity;
      logic display_on;
   } lcdm_ctl_t;

   localparam int CTL_W = $bits(lcdm_ctl_t);

   // scan state of the common driver
   typedef enum logic {
      SCAN_IDLE,
      SCAN_RUN
   } lcdm_scan_t;

endpackage

/* File: rtl/lcdm_shift.sv */
`timescale 1ns/10ps
// link-domain row shifter, one nibble per shift clock fall
module lcdm_shift #(
   parameter int SEG_COUNT = lcdm_pkg::SEG_COUNT_DEF
) (
   input wire logic data_shift_clock,
   input wire logic [lcdm_pkg::NIB_W-1:0] nibble_in,
   output logic [SEG_COUNT-1:0] row_bits
);

   logic [SEG_COUNT-1:0] row_q;

   // newest nibble enters at the top, first nibble ends at segment 0
   always_ff @(negedge data_shift_clock) begin
      row_q <= {nibble_in, row_q[SEG_COUNT-1:lcdm_pkg::NIB_W]};
   end

   assign row_bits = row_q;

endmodule // lcdm_shift

/* File: rtl/lcdm_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser, one lane per bit
module lcdm_sync #(
   parameter int WIDTH = lcdm_pkg::CTL_W
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_lane
         // first stage feeds only the second stage
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= async_in[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   assign sync_out = sync_q;

endmodule // lcdm_sync

/* File: rtl/lcdm_top.sv */
`timescale 1ns/10ps
// display-side drive logic of a controller-less graphic panel
module lcdm_top #(
   parameter int SEG_COUNT = lcdm_pkg::SEG_COUNT_DEF,
   parameter int ROW_COUNT = lcdm_pkg::ROW_COUNT_DEF,
   parameter bit DUAL_SCREEN = 1'b0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic data_shift_clock,
   input wire logic line_latch,
   input wire logic frame_start_pulse,
   input wire logic ac_polarity,
   input wire logic display_on_input,
   input wire logic [lcdm_pkg::NIB_W-1:0] pixel_nibble,
   input wire logic [lcdm_pkg::NIB_W-1:0] upper_half_nibble,
   input wire logic [lcdm_pkg::NIB_W-1:0] lower_half_nibble,
   output logic [SEG_COUNT-1:0] segment_electrode,
   output logic [SEG_COUNT-1:0] lower_segment_electrode,
   output logic [ROW_COUNT-1:0] common_electrode,
   output logic drive_polarity
);

   // rows scanned by one common counter
   localparam int SCAN_ROWS = DUAL_SCREEN ? ROW_COUNT / 2 : ROW_COUNT;
   localparam int ROW_W = (SCAN_ROWS > 1) ? $clog2(SCAN_ROWS) : 1;
   localparam logic [ROW_W-1:0] ROW_FIRST = '0;
   localparam logic [ROW_W-1:0] ROW_LAST = ROW_W'(SCAN_ROWS - 1);
   localparam logic [ROW_W-1:0] ROW_STEP = ROW_W'(1);
   localparam int MAX_ACTIVE = DUAL_SCREEN ? 2 : 1;

   // control pins gathered for the crossing
   lcdm_pkg::lcdm_ctl_t ctl_raw;
   lcdm_pkg::lcdm_ctl_t ctl_s;
   logic [lcdm_pkg::CTL_W-1:0] ctl_sync_bits;

   // link-domain row images
   logic [SEG_COUNT-1:0] upper_row_link;
   logic [SEG_COUNT-1:0] lower_row_link;
   logic [lcdm_pkg::NIB_W-1:0] upper_nib;

   // system-domain state
   logic latch_prev_q;
   logic latch_fall;
   lcdm_pkg::lcdm_scan_t scan_q;
   lcdm_pkg::lcdm_scan_t scan_d;
   logic [ROW_W-1:0] row_q;
   logic [ROW_W-1:0] row_d;
   logic [SEG_COUNT-1:0] upper_row_q;
   logic [SEG_COUNT-1:0] lower_row_q;
   logic [SEG_COUNT-1:0] seg_out_q;
   logic [SEG_COUNT-1:0] lower_seg_out_q;
   logic [ROW_COUNT-1:0] com_out_q;
   logic [ROW_COUNT-1:0] com_d;
   logic polarity_q;

   // pins into the crossing
   assign ctl_raw.line_latch = line_latch;
   assign ctl_raw.frame_start = frame_start_pulse;
   assign ctl_raw.ac_polarity = ac_polarity;
   assign ctl_raw.display_on = display_on_input;

   lcdm_sync #(
      .WIDTH(lcdm_pkg::CTL_W)
   ) u_ctl_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .async_in(ctl_raw),
      .sync_out(ctl_sync_bits)
   );

   assign ctl_s = lcdm_pkg::lcdm_ctl_t'(ctl_sync_bits);

   // single screen takes the plain group, dual screen the upper group
   assign upper_nib = DUAL_SCREEN ? upper_half_nibble : pixel_nibble;

   lcdm_shift #(
      .SEG_COUNT(SEG_COUNT)
   ) u_upper_shift (
      .data_shift_clock(data_shift_clock),
      .nibble_in(upper_nib),
      .row_bits(upper_row_link)
   );

   // lower group only exists on a dual screen
   generate
      if (DUAL_SCREEN) begin : g_dual
         lcdm_shift #(
            .SEG_COUNT(SEG_COUNT)
         ) u_lower_shift (
            .data_shift_clock(data_shift_clock),
            .nibble_in(lower_half_nibble),
            .row_bits(lower_row_link)
         );
      end else begin : g_single
         assign lower_row_link = '0;
      end
   endgenerate

   // falling edge of the synchronised line latch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         latch_prev_q <= 1'b0;
      end else begin
         latch_prev_q <= ctl_s.line_latch;
      end
   end

   assign latch_fall = latch_prev_q & ~ctl_s.line_latch;

   // row image capture; shift clock is quiet around the latch fall
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upper_row_q <= '0;
         lower_row_q <= '0;
      end else if (latch_fall) begin
         upper_row_q <= upper_row_link;
         lower_row_q <= lower_row_link;
      end
   end

   // scan state and row pointer, restarted by frame start
   always_comb begin
      scan_d = scan_q;
      row_d = row_q;
      if (latch_fall) begin
         if (ctl_s.frame_start) begin
            scan_d = lcdm_pkg::SCAN_RUN;
            row_d = ROW_FIRST;
         end else if (scan_q == lcdm_pkg::SCAN_RUN) begin
            row_d = (row_q == ROW_LAST) ? ROW_FIRST : row_q + ROW_STEP;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scan_q <= lcdm_pkg::SCAN_IDLE;
         row_q <= ROW_FIRST;
      end else begin
         scan_q <= scan_d;
         row_q <= row_d;
      end
   end

   // one-hot common select, a second line in the lower half on dual
   always_comb begin
      com_d = '0;
      unique case (scan_q)
         lcdm_pkg::SCAN_IDLE: begin
            com_d = '0;
         end
         lcdm_pkg::SCAN_RUN: begin
            com_d[row_q] = 1'b1;
            if (DUAL_SCREEN) begin
               com_d[SCAN_ROWS + int'(row_q)] = 1'b1;
            end
         end
      endcase
   end

   // output drivers, blanked by display-on
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seg_out_q <= '0;
         lower_seg_out_q <= '0;
         com_out_q <= '0;
      end else if (ctl_s.display_on) begin
         seg_out_q <= upper_row_q;
         lower_seg_out_q <= lower_row_q;
         com_out_q <= com_d;
      end else begin
         seg_out_q <= '0;
         lower_seg_out_q <= '0;
         com_out_q <= '0;
      end
   end

   // ac drive polarity follows the controller
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         polarity_q <= 1'b0;
      end else begin
         polarity_q <= ctl_s.ac_polarity;
      end
   end

   assign segment_electrode = seg_out_q;
   assign lower_segment_electrode = lower_seg_out_q;
   assign common_electrode = com_out_q;
   assign drive_polarity = polarity_q;

   // checks on the system clock
   default clocking cb_sys @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence latch_edge_s;
      latch_fall && !ctl_s.frame_start && scan_q == lcdm_pkg::SCAN_RUN;
   endsequence

   sequence frame_edge_s;
      latch_fall && ctl_s.frame_start;
   endsequence

   sequence row_shown_s;
      ctl_s.display_on && scan_q == lcdm_pkg::SCAN_RUN;
   endsequence

   sequence first_row_s;
      frame_edge_s ##1 ctl_s.display_on;
   endsequence

   // at most one line is driven, two on a dual screen
   one_line_a: assert property ($countones(common_electrode) <= MAX_ACTIVE)
      else $error("more common lines active than allowed");

   // driven line matches the row pointer
   line_matches_a: assert property (row_shown_s |=> common_electrode[$past(row_q)])
      else $error("common line does not match row pointer");

   // row pointer steps by one and wraps
   row_step_a: assert property (latch_edge_s |=>
      row_q == (($past(row_q) == ROW_LAST) ? ROW_FIRST : $past(row_q) + ROW_STEP))
      else $error("row pointer did not advance");

   // frame start sends the scan back to the first row
   frame_restart_a: assert property (frame_edge_s |=>
      row_q == ROW_FIRST && scan_q == lcdm_pkg::SCAN_RUN)
      else $error("frame start did not restart scan");

   // latched row equals the shifted image
   row_capture_a: assert property (latch_fall |=> upper_row_q == $past(upper_row_link))
      else $error("row image not captured at line latch");

   // capture lands before the next shift may come
   latch_timely_a: assert property ($fell(line_latch) |-> ##[1:3] latch_fall)
      else $error("line latch not seen in time");

   // blank when display-on is low
   blank_off_a: assert property (!ctl_s.display_on |=>
      common_electrode == '0 && segment_electrode == '0)
      else $error("display not blanked");

   // shown pixels are exactly the latched bits
   pixels_shown_a: assert property (ctl_s.display_on |=>
      segment_electrode == $past(upper_row_q) && common_electrode == $past(com_d))
      else $error("segments differ from latched row");

   // lower group stays silent on a single screen
   lower_idle_a: assert property (!DUAL_SCREEN |-> lower_segment_electrode == '0)
      else $error("lower segments driven on single screen");

   // dual screen drives the matching lower-half line too
   dual_pair_a: assert property ((row_shown_s and DUAL_SCREEN) |=>
      common_electrode[SCAN_ROWS + int'($past(row_q))])
      else $error("lower half line not driven");

   // no line driven before the first frame start
   idle_dark_a: assert property (scan_q == lcdm_pkg::SCAN_IDLE |=>
      common_electrode == '0)
      else $error("line driven before frame start");

   // frame start then display on shows the first line
   frame_show_a: assert property (first_row_s |=>
      common_electrode[ROW_FIRST])
      else $error("first line not shown after frame start");

   // row pointer moves only at a line latch fall
   row_hold_a: assert property (!latch_fall |=>
      $stable(row_q))
      else $error("row pointer moved without line latch");

   // latched rows hold between line latches
   capture_hold_a: assert property (!latch_fall |=>
      $stable(upper_row_q) && $stable(lower_row_q))
      else $error("latched row changed without line latch");

   // lower row image captured together with the upper one
   lower_capture_a: assert property (latch_fall |=>
      lower_row_q == $past(lower_row_link))
      else $error("lower row image not captured");

   // lower segments show the lower latched row
   lower_shown_a: assert property (ctl_s.display_on |=>
      lower_segment_electrode == $past(lower_row_q))
      else $error("lower segments differ from latched row");

   // lower segments blank with the rest
   lower_blank_a: assert property (!ctl_s.display_on |=>
      lower_segment_electrode == '0)
      else $error("lower segments not blanked");

   // once running the scan never falls back to idle
   scan_stays_a: assert property (scan_q == lcdm_pkg::SCAN_RUN |=>
      scan_q == lcdm_pkg::SCAN_RUN)
      else $error("scan left run state");

   // idle scan waits for a line latch with frame start
   idle_hold_a: assert property (scan_q == lcdm_pkg::SCAN_IDLE && !latch_fall |=>
      scan_q == lcdm_pkg::SCAN_IDLE)
      else $error("scan started without frame start");

   // drive polarity is the synchronised ac level, one cycle on
   polarity_follow_a: assert property (
      drive_polarity == $past(ctl_s.ac_polarity))
      else $error("drive polarity does not follow ac level");

endmodule // lcdm_top

/* File: test/lcdm_ctl_model.sv */
`timescale 1ns/10ps
// controller model: shift clock, nibbles, latch, frame start, polarity
module lcdm_ctl_model #(
   parameter int SEG_COUNT = 16
) (
   output logic data_shift_clock,
   output logic line_latch,
   output logic frame_start_pulse,
   output logic ac_polarity,
   output logic [lcdm_pkg::NIB_W-1:0] pixel_nibble,
   output logic [lcdm_pkg::NIB_W-1:0] upper_half_nibble,
   output logic [lcdm_pkg::NIB_W-1:0] lower_half_nibble
);
   // link idle: shift clock still, data lines at their rest value
   initial begin
      data_shift_clock = 1'b0;
      line_latch = 1'b0;
      frame_start_pulse = 1'b0;
      ac_polarity = 1'b0;
      pixel_nibble = 4'h0;
      upper_half_nibble = 4'h0;
      lower_half_nibble = 4'h0;
   end

   // one row of nibbles, then the latch; first row carries frame start
   task automatic send_row(input logic [SEG_COUNT-1:0] row, input logic first);
      logic [3:0] nib;
      for (int i = 0; i < SEG_COUNT / 4; i++) begin
         nib = row[4*i +: 4];
         pixel_nibble = nib;
         upper_half_nibble = nib;
         lower_half_nibble = ~nib;
         #3.75 data_shift_clock = 1'b1;
         #7.5 data_shift_clock = 1'b0;
         #3.75;
      end
      pixel_nibble = ~nib; // released line shows inverse
      upper_half_nibble = ~nib;
      lower_half_nibble = nib;
      if (first) begin
         frame_start_pulse = 1'b1;
         ac_polarity = ~ac_polarity;
      end
      #130 line_latch = 1'b1;
      #130 line_latch = 1'b0;
      #110 frame_start_pulse = 1'b0;
   endtask
endmodule // lcdm_ctl_model

/* File: test/tb.sv */
`timescale 1ns/10ps
// bench for the panel drive logic
module tb;
   localparam int SEG = 16;
   localparam int ROWS = 4;
   localparam int HALF = ROWS / 2;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic display_on_input = 1'b0;
   logic dsc, latch, fsp, acp;
   logic [3:0] nib, unib, lnib;
   logic [SEG-1:0] seg, lseg;
   logic [ROWS-1:0] com;
   logic pol;
   logic [SEG-1:0] seg_dl, lseg_dl;
   logic [ROWS-1:0] com_dl;
   logic pol_dl;
   logic pol_exp = 1'b0;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #4 clk = ~clk;

   lcdm_ctl_model #(.SEG_COUNT(SEG)) ctl (.data_shift_clock(dsc), .line_latch(latch),
      .frame_start_pulse(fsp), .ac_polarity(acp), .pixel_nibble(nib),
      .upper_half_nibble(unib), .lower_half_nibble(lnib));

   lcdm_top #(.SEG_COUNT(SEG), .ROW_COUNT(ROWS)) DUT (.clk(clk), .sys_rst(sys_rst),
      .data_shift_clock(dsc), .line_latch(latch), .frame_start_pulse(fsp),
      .ac_polarity(acp), .display_on_input(display_on_input), .pixel_nibble(nib),
      .upper_half_nibble(unib), .lower_half_nibble(lnib), .segment_electrode(seg),
      .lower_segment_electrode(lseg), .common_electrode(com), .drive_polarity(pol));

   lcdm_top #(.SEG_COUNT(SEG), .ROW_COUNT(ROWS), .DUAL_SCREEN(1'b1)) DUT_DUAL (.clk(clk),
      .sys_rst(sys_rst), .data_shift_clock(dsc), .line_latch(latch), .frame_start_pulse(fsp),
      .ac_polarity(acp), .display_on_input(display_on_input), .pixel_nibble(nib),
      .upper_half_nibble(unib), .lower_half_nibble(lnib), .segment_electrode(seg_dl),
      .lower_segment_electrode(lseg_dl), .common_electrode(com_dl), .drive_polarity(pol_dl));

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // one row through the link, then segments, commons and polarity
   task automatic row_check(input logic [SEG-1:0] row, input logic first, input int idx);
      if (first) begin
         pol_exp = ~pol_exp;
      end
      ctl.send_row(row, first);
      wait_clk(4);
      check(64'(seg), 64'(row));
      check(64'(com), 64'(1) << idx);
      check(64'(lseg), 64'h0);
      check(64'(pol), 64'(pol_exp));
      check(64'(seg_dl), 64'(row));
      check(64'(lseg_dl), 64'({~row}));
      check(64'(com_dl), (64'(1) | (64'(1) << HALF)) << (idx % HALF));
      check(64'(pol_dl), 64'(pol_exp));
   endtask

   // after reset all outputs dark, commons stay dark before a frame start
   task automatic t_reset;
      check(64'({pol, com, lseg, seg}), 64'h0);
      check(64'({pol_dl, com_dl, lseg_dl, seg_dl}), 64'h0);
      display_on_input = 1'b1;
      ctl.send_row(16'hffff, 1'b0);
      wait_clk(4);
      check(64'(com), 64'h0);
      check(64'(com_dl), 64'h0);
      check(64'(seg), 64'hffff);
   endtask

   // full scan, wrap, and a frame start in mid-scan
   task automatic t_frame;
      for (int r = 0; r < ROWS; r++) begin
         row_check(16'h0001 << (5 * r) | 16'h8000 >> r, r == 0, r);
      end
      row_check(16'ha5c3, 1'b0, 0);
      row_check(16'h3c5a, 1'b0, 1);
      row_check(16'hf00f, 1'b1, 0);
   endtask

   // blanking clears segments and commons, showing restores them
   task automatic t_blank;
      display_on_input = 1'b0;
      wait_clk(4);
      check(64'(seg), 64'h0);
      check(64'(com), 64'h0);
      check(64'({com_dl, lseg_dl, seg_dl}), 64'h0);
      display_on_input = 1'b1;
      wait_clk(4);
      check(64'(seg), 64'hf00f);
      check(64'(com), 64'h1);
      check(64'(seg_dl), 64'hf00f);
      check(64'(lseg_dl), 64'h0ff0);
      check(64'(com_dl), 64'(1) | (64'(1) << HALF));
   endtask

   // cycle ceiling against a hang
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         summarize();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      #1 sys_rst = 1'b0;
      wait_clk(1);
      t_reset();
      t_frame();
      t_blank();
      summarize();
   end
endmodule // tb
